// file: design/sep_eeprom.sv
`default_nettype none
module sep_eeprom #(
   parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic clk_en,
   input  wire logic select_n,
   input  wire logic serial_clock,
   input  wire logic serial_data_in,
   input  wire logic reset_pin,
   output var  logic serial_data_out,
   output var  logic serial_data_out_en,
   output var  logic write_status_pin
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0]          pin_raw;
   logic [3:0]          pin_meta;
   logic [3:0]          pin_sync;
   logic                sk_d;
   assign pin_raw = {reset_pin, serial_data_in, serial_clock, select_n};

   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               pin_meta[gp] <= sep_pkg::PIN_RST[gp];
               pin_sync[gp] <= sep_pkg::PIN_RST[gp];
            end else if (clk_en) begin
               pin_meta[gp] <= pin_raw[gp];
               pin_sync[gp] <= pin_meta[gp];
            end
         end
      end
   endgenerate

   wire cs_n_s  = pin_sync[0];
   wire sk_s    = pin_sync[1];
   wire di_s    = pin_sync[2];
   wire rst_s   = pin_sync[3];
   wire sk_rise = sk_s & ~sk_d;
   wire sk_fall = ~sk_s & sk_d;

   always_ff @(posedge clk_sys) begin
      if (srst) sk_d <= 1'b0;
      else if (clk_en) sk_d <= sk_s;
   end

   // ----------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------
   sep_pkg::sep_rx_t    rx_state;
   sep_pkg::sep_eng_t   eng_state;
   logic [3:0]          hunt_sr;
   logic [27:0]         body_sr;
   logic [4:0]          bit_cnt;
   logic [15:0]         rd_sr;
   logic [4:0]          rd_cnt;
   logic                rd_bit;
   logic                rd_drive;
   logic                prog_en;
   logic                status_mode;
   logic [15:0]         mem [sep_pkg::WORDS];
   logic [24:0]         buf0;
   logic [24:0]         buf1;
   logic [1:0]          buf_cnt;
   logic [24:0]         eng_entry;
   logic [sep_pkg::TIMER_W-1:0] timer;

   // ----------------------------------------------------------------
   // receiver decode
   // ----------------------------------------------------------------
   wire [27:0] next_body  = {body_sr[26:0], di_s};
   wire [4:0]  next_cnt   = bit_cnt + 5'h01;
   wire [3:0]  next_hunt  = {hunt_sr[2:0], di_s};
   wire [3:0]  hdr_op     = next_body[11:8];
   wire [7:0]  hdr_addr   = next_body[7:0];
   wire        op_is_wr   = hdr_op == sep_pkg::OP_WRITE || hdr_op == sep_pkg::OP_FILL;
   wire        hdr_done   = rx_state == sep_pkg::RX_BODY && sk_rise && next_cnt == sep_pkg::HDR_BITS;
   wire        body_done  = rx_state == sep_pkg::RX_BODY && sk_rise && next_cnt == sep_pkg::WR_BITS;
   // reset while a write is still arriving
   wire        wr_cancel  = rx_state == sep_pkg::RX_BODY && bit_cnt >= sep_pkg::HDR_BITS && rst_s;
   wire [24:0] push_entry = {body_sr[27:24] == sep_pkg::OP_FILL, body_sr[23:0]};
   wire        buf_in_rdy = buf_cnt != 2'h2;
   wire        push       = rx_state == sep_pkg::RX_PUSH && buf_in_rdy && !rst_s;

   // ----------------------------------------------------------------
   // receiver state machine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rx_state <= sep_pkg::RX_HUNT;
         hunt_sr  <= 4'h0;
         body_sr  <= 28'h0000000;
         bit_cnt  <= 5'h00;
      // deselect restarts framing; a finished write still waits for room
      end else if (clk_en && cs_n_s && rx_state != sep_pkg::RX_PUSH) begin
         rx_state <= sep_pkg::RX_HUNT;
         hunt_sr  <= 4'h0;
         bit_cnt  <= 5'h00;
      end else if (clk_en) begin
         unique case (rx_state)
            sep_pkg::RX_HUNT: begin
               if (sk_rise) begin
                  hunt_sr <= next_hunt;
                  if (next_hunt == sep_pkg::START_PAT) begin
                     rx_state <= sep_pkg::RX_BODY;
                     bit_cnt  <= 5'h00;
                  end
               end
            end
            sep_pkg::RX_BODY: begin
               if (wr_cancel) begin
                  rx_state <= sep_pkg::RX_IDLE;
               end else if (sk_rise) begin
                  body_sr <= next_body;
                  bit_cnt <= next_cnt;
                  if (hdr_done) begin
                     if (hdr_op == sep_pkg::OP_READ) begin
                        rx_state <= sep_pkg::RX_READ;
                     end else if (!(op_is_wr && prog_en)) begin
                        rx_state <= sep_pkg::RX_IDLE;
                     end
                  end else if (body_done) begin
                     rx_state <= sep_pkg::RX_PUSH;
                  end
               end
            end
            sep_pkg::RX_PUSH: begin
               if (rst_s || push) rx_state <= sep_pkg::RX_IDLE;
            end
            sep_pkg::RX_READ: rx_state <= sep_pkg::RX_READ;
            sep_pkg::RX_IDLE: rx_state <= sep_pkg::RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // program enable latch
   // ----------------------------------------------------------------
   // locked from power-up; reset pin not involved
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prog_en <= 1'b0;
      end else if (clk_en && hdr_done) begin
         if (hdr_op == sep_pkg::OP_UNLOCK) prog_en <= 1'b1;
         else if (hdr_op == sep_pkg::OP_LOCK) prog_en <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read shifter
   // ----------------------------------------------------------------
   // load on clock 16, first bit on the following fall
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_sr    <= 16'h0000;
         rd_cnt   <= 5'h00;
         rd_bit   <= 1'b0;
         rd_drive <= 1'b0;
      end else if (clk_en) begin
         if (cs_n_s) begin
            rd_drive <= 1'b0;
         end else if (hdr_done && hdr_op == sep_pkg::OP_READ) begin
            rd_sr  <= mem[hdr_addr];
            rd_cnt <= 5'h00;
         end else if (rx_state == sep_pkg::RX_READ && sk_fall && rd_cnt != sep_pkg::RD_BITS) begin
            rd_bit   <= rd_sr[15];
            rd_sr    <= {rd_sr[14:0], 1'b0};
            rd_cnt   <= rd_cnt + 5'h01;
            rd_drive <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // two-entry write buffer
   // ----------------------------------------------------------------
   wire buf_out_vld = buf_cnt != 2'h0;
   wire buf_out_rdy = eng_state == sep_pkg::EN_IDLE;
   wire pop         = buf_out_vld && buf_out_rdy && !rst_s;

   // reset pin flushes pending writes too
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         buf_cnt <= 2'h0;
         buf0    <= 25'h0000000;
         buf1    <= 25'h0000000;
      end else if (clk_en && rst_s) begin
         buf_cnt <= 2'h0;
      end else if (clk_en) begin
         if (push && !pop) begin
            if (buf_cnt == 2'h0) buf0 <= push_entry;
            else buf1 <= push_entry;
            buf_cnt <= buf_cnt + 2'h1;
         end else if (pop && !push) begin
            buf0    <= buf1;
            buf_cnt <= buf_cnt - 2'h1;
         end else if (pop && push) begin
            if (buf_cnt == 2'h1) buf0 <= push_entry;
            else begin
               buf0 <= buf1;
               buf1 <= push_entry;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // self-timed clear and program engine
   // ----------------------------------------------------------------
   localparam logic [sep_pkg::TIMER_W-1:0] CLEAR_LEN = sep_pkg::TIMER_W'(PROG_CYCLES / 2);
   localparam logic [sep_pkg::TIMER_W-1:0] PROG_LEN  = sep_pkg::TIMER_W'(PROG_CYCLES - PROG_CYCLES / 2);
   wire timer_done = timer == '0;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         eng_state <= sep_pkg::EN_IDLE;
         timer     <= '0;
         eng_entry <= 25'h0000000;
      end else if (clk_en && rst_s) begin
         eng_state <= sep_pkg::EN_IDLE;
      end else if (clk_en) begin
         unique case (eng_state)
            sep_pkg::EN_IDLE: begin
               if (pop) begin
                  eng_entry <= buf0;
                  timer     <= CLEAR_LEN - 1'b1;
                  eng_state <= sep_pkg::EN_CLEAR;
               end
            end
            sep_pkg::EN_CLEAR: begin
               if (timer_done) begin
                  timer     <= PROG_LEN - 1'b1;
                  eng_state <= sep_pkg::EN_PROG;
               end else timer <= timer - 1'b1;
            end
            sep_pkg::EN_PROG: begin
               if (timer_done) eng_state <= sep_pkg::EN_IDLE;
               else timer <= timer - 1'b1;
            end
         endcase
      end
   end

   wire        mem_we    = !rst_s && timer_done &&
                           (eng_state == sep_pkg::EN_CLEAR || eng_state == sep_pkg::EN_PROG);
   wire [15:0] mem_wdata = eng_state == sep_pkg::EN_CLEAR ? sep_pkg::ERASED_WORD : eng_entry[15:0];
   wire        mem_all   = eng_entry[24];
   wire [7:0]  mem_addr  = eng_entry[23:16];

   // ----------------------------------------------------------------
   // nonvolatile array
   // ----------------------------------------------------------------
   // 256 x 16; array is kept across srst like real cells
   genvar gw;
   generate
      for (gw = 0; gw < sep_pkg::WORDS; gw++) begin : g_word
         always_ff @(posedge clk_sys) begin
            if (clk_en && mem_we && (mem_all || mem_addr == 8'(gw))) mem[gw] <= mem_wdata;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // status and output pins
   // ----------------------------------------------------------------
   wire busy = rx_state == sep_pkg::RX_PUSH || buf_cnt != 2'h0 || eng_state != sep_pkg::EN_IDLE;
   wire status_clr = !busy && !cs_n_s && sk_rise && di_s;

   always_ff @(posedge clk_sys) begin
      if (srst) status_mode <= 1'b0;
      else if (clk_en && push) status_mode <= 1'b1;
      else if (clk_en && status_clr) status_mode <= 1'b0;
   end

   // drive only for read data or polled status
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         serial_data_out    <= 1'b0;
         serial_data_out_en <= 1'b0;
         write_status_pin   <= 1'b1;
      end else if (clk_en) begin
         serial_data_out_en <= !cs_n_s && (rd_drive || status_mode);
         serial_data_out    <= rd_drive ? rd_bit : !busy;
         write_status_pin   <= !busy;
      end
   end
endmodule
`default_nettype wire

// file: pkg/sep_pkg.sv
`default_nettype none
package sep_pkg;
   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int WORDS  = 256;

   // ----------------------------------------------------------------
   // instruction format
   // ----------------------------------------------------------------
   localparam logic [3:0]  START_PAT    = 4'ha;
   localparam logic [3:0]  OP_READ      = 4'h8;
   localparam logic [3:0]  OP_WRITE     = 4'h4;
   localparam logic [3:0]  OP_UNLOCK    = 4'h3;
   localparam logic [3:0]  OP_LOCK      = 4'h0;
   localparam logic [3:0]  OP_FILL      = 4'h1;
   localparam logic [4:0]  HDR_BITS     = 5'h0c;
   localparam logic [4:0]  WR_BITS      = 5'h1c;
   localparam logic [4:0]  RD_BITS      = 5'h10;
   localparam logic [15:0] ERASED_WORD  = 16'hffff;
   localparam logic [3:0]  PIN_RST      = 4'h1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_HZ  = 50_000_000;
   localparam int PROG_TIME_MS = 5;
   localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int TIMER_W      = 18;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {RX_HUNT, RX_BODY, RX_PUSH, RX_READ, RX_IDLE} sep_rx_t;
   typedef enum logic [1:0] {EN_IDLE, EN_CLEAR, EN_PROG} sep_eng_t;
endpackage
`default_nettype wire

// file: tb/sep_eeprom_sva.sv
`default_nettype none
module sep_eeprom_sva #(
   parameter int PROG_CYCLES = 40
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic select_n,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   input wire logic reset_pin,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en,
   input wire logic write_status_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ---
   // busy length tracking
   // ---
   int   busy_cnt;
   logic rst_seen;
   always_ff @(posedge clk_sys) begin
      if (srst || write_status_pin) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   // a reset pulse may legally cut busy short
   always_ff @(posedge clk_sys) begin
      if (srst || (write_status_pin && !reset_pin)) begin
         rst_seen <= 1'b0;
      end else if (reset_pin) begin
         rst_seen <= 1'b1;
      end
   end
   a_srst_idle: assert property ($fell(srst) |-> !serial_data_out_en && write_status_pin)
      else $error("outputs not idle after reset");
   a_desel_float: assert property (select_n [*5] |-> !serial_data_out_en)
      else $error("output driven while deselected");
   a_busy_low: assert property (serial_data_out_en && !write_status_pin |-> !serial_data_out)
      else $error("busy status not low on output");
   a_ready_drive: assert property ($rose(write_status_pin) && serial_data_out_en
      |-> ##[0:2] (serial_data_out || !serial_data_out_en))
      else $error("ready not shown on output");
   a_abort_ready: assert property (reset_pin [*6] |-> write_status_pin)
      else $error("reset did not give ready");
   a_busy_full: assert property ($rose(write_status_pin) && !rst_seen |-> busy_cnt >= PROG_CYCLES - 2)
      else $error("busy period too short");
   a_busy_bound: assert property (!write_status_pin |-> busy_cnt <= 260 * PROG_CYCLES)
      else $error("busy period never ends");
   a_read_fall: assert property ($changed(serial_data_out) && serial_data_out_en
      && $past(serial_data_out_en) && write_status_pin && $past(write_status_pin) |-> !serial_clock)
      else $error("read data changed off falling edge");
   a_freeze_hold: assert property (!clk_en |=> $stable({serial_data_out, serial_data_out_en, write_status_pin}))
      else $error("outputs moved while frozen");
endmodule
bind sep_eeprom sep_eeprom_sva #(.PROG_CYCLES(PROG_CYCLES)) i_sep_eeprom_sva (
   .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .select_n(select_n), .serial_clock(serial_clock),
   .serial_data_in(serial_data_in), .reset_pin(reset_pin), .serial_data_out(serial_data_out),
   .serial_data_out_en(serial_data_out_en), .write_status_pin(write_status_pin));
`default_nettype wire

// file: tb/sep_host_model.sv
`default_nettype none
module sep_host_model (
   input  wire logic        clk_sys,
   input  wire logic        go,
   input  wire logic [39:0] frame,
   input  wire logic [5:0]  nbits,
   input  wire logic        keep_sel,
   input  wire logic        serial_data_out,
   input  wire logic        serial_data_out_en,
   output var  logic        select_n,
   output var  logic        serial_clock,
   output var  logic        serial_data_in,
   output var  logic        done,
   output var  logic [15:0] rd_word
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 6;
   logic line_q = 1'b0;
   // no pull on a released line: it shows the inverse of the last driven bit
   wire logic line = serial_data_out_en ? serial_data_out : ~line_q;
   always @(posedge clk_sys) begin
      if (serial_data_out_en) line_q <= serial_data_out;
   end
   initial begin
      select_n = 1'b1;
      serial_clock = 1'b0;
      serial_data_in = 1'b0;
      done = 1'b0;
      rd_word = 16'h0000;
      forever begin
         @(posedge clk_sys);
         if (go) begin
            if (select_n) begin
               select_n <= 1'b0;
               repeat (HALF) @(posedge clk_sys);
            end
            // msb first, data set while clock low
            for (int i = int'(nbits) - 1; i >= 0; i--) begin
               serial_data_in <= frame[i];
               repeat (HALF) @(posedge clk_sys);
               serial_clock <= 1'b1;
               rd_word <= {rd_word[14:0], line};
               repeat (HALF) @(posedge clk_sys);
               serial_clock <= 1'b0;
            end
            serial_data_in <= 1'b0;
            repeat (HALF) @(posedge clk_sys);
            if (!keep_sel) begin
               select_n <= 1'b1;
               repeat (HALF) @(posedge clk_sys);
            end
            done <= 1'b1;
            @(posedge clk_sys);
            done <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_sep_eeprom.sv
`default_nettype none
module tb_sep_eeprom;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 1500;
   logic        clk_sys, srst, clk_en, reset_pin, go, keep_sel;
   logic [39:0] frame;
   logic [5:0]  nbits;
   wire logic   select_n, serial_clock, serial_data_in, serial_data_out, serial_data_out_en, write_status_pin, done;
   wire logic [15:0] rd_word;
   int          fails = 0;
   int          n_checks = 0;
   sep_eeprom #(.PROG_CYCLES(PROG)) i_sep_eeprom (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
      .select_n(select_n), .serial_clock(serial_clock), .serial_data_in(serial_data_in), .reset_pin(reset_pin),
      .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en), .write_status_pin(write_status_pin));
   sep_host_model i_sep_host_model (.clk_sys(clk_sys), .go(go), .frame(frame), .nbits(nbits), .keep_sel(keep_sel),
      .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en), .select_n(select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in), .done(done), .rd_word(rd_word));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ---
   // helpers
   // ---
   task automatic complete_run();
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // status pin, output enable, driven output value
   function automatic logic [15:0] pins();
      return {13'h0, write_status_pin, serial_data_out_en, serial_data_out_en & serial_data_out};
   endfunction
   task automatic waitfor(input logic which, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk_sys);
         if ((which ? write_status_pin : done) === 1'b1) break;
      end
      if (i == lim) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic send(input logic [39:0] f, input logic [5:0] n, input logic k);
      frame <= f;
      nbits <= n;
      keep_sel <= k;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      waitfor(1'b0, 2000);
   endtask
   task automatic ready();
      waitfor(1'b1, 30000);
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic k);
      send({8'h0, sep_pkg::START_PAT, sep_pkg::OP_WRITE, a, d}, 6'd32, k);
   endtask
   task automatic cmd(input logic [3:0] op);
      send({24'h0, sep_pkg::START_PAT, op, 8'h00}, 6'd16, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      send({8'h0, sep_pkg::START_PAT, sep_pkg::OP_READ, a, 16'h0}, 6'd32, 1'b0);
      check(rd_word, exp);
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_lock();
      wr(8'h5a, 16'h1234, 1'b0);
      check(pins(), 16'h4);
      cmd(sep_pkg::OP_UNLOCK);
      wr(8'h5a, 16'ha55a, 1'b0);
      check(pins(), 16'h0);
      ready();
      rd(8'h5a, 16'ha55a);
      cmd(sep_pkg::OP_LOCK);
      wr(8'h5a, 16'h0000, 1'b0);
      check(pins(), 16'h4);
      rd(8'h5a, 16'ha55a);
   endtask
   task automatic t_poll();
      cmd(sep_pkg::OP_UNLOCK);
      wr(8'h03, 16'h8001, 1'b1);
      check(pins(), 16'h2);
      ready();
      check(pins(), 16'h7);
      send(40'h1, 6'd1, 1'b1);
      check(pins(), 16'h4);
      send(40'h0, 6'd0, 1'b0);
      rd(8'h03, 16'h8001);
   endtask
   task automatic t_reset();
      wr(8'h03, 16'h0f0f, 1'b1);
      reset_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check(pins(), 16'h7);
      reset_pin <= 1'b0;
      send(40'h0, 6'd0, 1'b0);
      wr(8'h04, 16'h4444, 1'b0);
      check(pins(), 16'h0);
      ready();
      // abort in the program half leaves the cleared word
      wr(8'h06, 16'h1234, 1'b0);
      repeat (PROG * 3 / 5) @(posedge clk_sys);
      reset_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(8'h06, sep_pkg::ERASED_WORD);
      wr(8'h04, 16'h1111, 1'b1);
      check(pins(), 16'h4);
      send(40'h0, 6'd0, 1'b0);
      rd(8'h04, 16'h4444);
      cmd(sep_pkg::OP_LOCK);
      reset_pin <= 1'b0;
      wr(8'h05, 16'h5555, 1'b0);
      check(pins(), 16'h4);
   endtask
   task automatic t_stream();
      cmd(sep_pkg::OP_UNLOCK);
      send({3'h0, 5'h04, sep_pkg::START_PAT, sep_pkg::OP_READ, 8'h04, 16'h0}, 6'd37, 1'b0);
      check(rd_word, 16'h4444);
      for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i), 16'h1111 * 16'(i + 1), 1'b0);
      ready();
      for (int i = 0; i < 4; i++) rd(8'h10 + 8'(i), 16'h1111 * 16'(i + 1));
      send({8'h0, sep_pkg::START_PAT, sep_pkg::OP_FILL, 8'h00, 16'hc3c3}, 6'd32, 1'b0);
      ready();
      rd(8'h00, 16'hc3c3);
      rd(8'hff, 16'hc3c3);
   endtask
   initial begin
      srst = 1'b1;
      clk_en = 1'b1;
      reset_pin = 1'b0;
      go = 1'b0;
      keep_sel = 1'b0;
      frame = '0;
      nbits = '0;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      t_lock();
      clk_en <= 1'b0;
      repeat (3) @(posedge clk_sys);
      clk_en <= 1'b1;
      t_poll();
      t_reset();
      t_stream();
      complete_run();
   end
endmodule
`default_nettype wire
